// ### core/uart_sleep_baud.sv
// Purpose: Sleep control, receive time-out, break and baud generator
// Assumes: Datapath status inputs come from logic on clk_sys
// Notes: Divisor bytes keep their value through both resets
//
// Summary of operation
// - Sleep allowed only with enhanced-functions and sleep-enable bits set.
// - Sleep needs idle rx line, empty transmitter, no other interrupts.
// - Never enter sleep while the receive FIFO holds data.
// - While asleep the UART clock is gated and state holds.
// - Wake on receive edge, modem input change or transmit FIFO write.
// - Time-out after four character times below the receive trigger.
// - Time-out count restarts at stop-bit middle or receive FIFO read.
// - Break when receive line stays low beyond one full frame.
// - Send-break bit holds the transmit line low until cleared.
// - Baud divider uses a 16-bit divisor from 1 to 65535.
// - Prescaler divides by 1 or 4 by modem control bit 7.
// - Prescaler is divide-by-1 after reset.
// - Divisor is high byte over low byte; rate formula as given.
// - Sample rate is 16 minus adjust plus numerator.
// - Zero divisor produces no baud clock at all.
// - One baud output clocks both transmitter and receiver.
// - Resets leave the divisor bytes unchanged.
`timescale 1ns/100ps
module uart_sleep_baud
  import uart_sleep_baud_pkg::*;
(
  input wire logic clk_sys, // System clock, 20 MHz
  input wire logic rst, // Async reset, active high
  input wire logic soft_rst, // Software reset pulse
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [3:0] reg_addr, // Register index
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, one cycle later
  input wire logic rx_in, // Receive pin
  input wire logic [3:0] modem_in, // Modem input pins
  input wire logic rx_busy, // Receiver inside a frame
  input wire logic rx_fifo_empty, // Receive FIFO empty
  input wire logic rx_below_trigger, // Receive FIFO under trigger
  input wire logic rx_fifo_read, // Host read of receive FIFO
  input wire logic rx_stop_mid, // Middle of received stop bit
  input wire logic tx_fifo_empty, // Transmit FIFO empty
  input wire logic tx_shift_empty, // Transmit shifter empty
  input wire logic tx_fifo_write, // Host write to transmit FIFO
  input wire logic irq_other, // Pending non-transmit interrupt
  input wire logic tx_data_in, // Serial data from transmitter
  output logic tx_out, // Transmit pin
  output logic asleep, // Sleep state
  output logic uart_clk_en, // Enable for UART clock gate
  output logic sample_tick, // Oversampling tick, tx and rx
  output logic bit_tick, // One pulse per bit time
  output logic rx_timeout, // Receive time-out flag
  output logic break_det // Line break detected
);

  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] irq_enable_ctrl;
    logic [7:0] enhanced_feature_ctrl;
    logic [3:0] sample_count_adjust;
    logic [3:0] clock_prescale_numerator;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic [3:0] md_s1;
    logic [3:0] md_s2;
    logic [3:0] md_s3;
    logic asleep;
    logic clk_on;
    logic [1:0] pre_cnt;
    logic [15:0] div_cnt;
    logic [5:0] smp_cnt;
    logic smp_tick;
    logic bit_tick;
    logic [6:0] to_cnt;
    logic to_flag;
    logic [4:0] brk_cnt;
    logic brk_flag;
    logic tx_line;
    logic [7:0] rdata;
  } state_t;

  localparam state_t STATE_RST = '{
    line_control: LINE_CTRL_RST,
    modem_control: CTRL_RST,
    irq_enable_ctrl: CTRL_RST,
    enhanced_feature_ctrl: CTRL_RST,
    sample_count_adjust: FIELD_RST,
    clock_prescale_numerator: FIELD_RST,
    rx_s1: 1'b1, rx_s2: 1'b1, rx_s3: 1'b1,
    md_s1: 4'h0, md_s2: 4'h0, md_s3: 4'h0,
    clk_on: 1'b1, tx_line: 1'b1,
    default: '0
  };

  state_t st;
  state_t next_st;
  logic [7:0] baud_divisor_low;
  logic [7:0] baud_divisor_high;
  logic [15:0] divisor;
  logic [5:0] srate_last;
  logic [4:0] char_bits;
  logic [6:0] to_limit;
  logic sleep_ok;
  logic wake;
  logic enter;
  logic to_restart;
  logic to_set;
  logic pre_done;

  // ---------------------------------------------------------------
  // Divisor bytes, no reset
  // ---------------------------------------------------------------
  // divisor survives resets
  always_ff @(posedge clk_sys) begin
    if (reg_wr && reg_addr == OFS_DIV_LOW) begin
      baud_divisor_low <= reg_wdata;
    end
    if (reg_wr && reg_addr == OFS_DIV_HIGH) begin
      baud_divisor_high <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Derived values
  // ---------------------------------------------------------------
  // divisor concatenation
  assign divisor = {baud_divisor_high, baud_divisor_low};
  always_comb begin
    srate_last = 6'(SAMPLE_BASE - 6'(st.sample_count_adjust)
                 + 6'(st.clock_prescale_numerator));
    if (srate_last != 6'h0) begin
      srate_last = srate_last - 6'h1;
    end
  end
  assign char_bits = START_BITS + MIN_WORD_BITS
                     + 5'(st.line_control[1:0])
                     + 5'(st.line_control[PARITY_EN_BIT])
                     + (st.line_control[STOP_BITS_BIT] ? 5'h2 : 5'h1);
  assign to_limit = {char_bits, 2'b00};
  assign sleep_ok = st.enhanced_feature_ctrl[ENH_FUNC_BIT]
                    && st.irq_enable_ctrl[SLEEP_EN_BIT];
  assign wake = (st.rx_s2 ^ st.rx_s3) || (st.md_s2 != st.md_s3)
                || tx_fifo_write;
  assign enter = sleep_ok && st.rx_s2 && !rx_busy && tx_fifo_empty
                 && tx_shift_empty && !irq_other && !st.to_flag
                 && rx_fifo_empty;
  assign pre_done = !st.modem_control[PRESC_SEL_BIT]
                    || st.pre_cnt == PRESC_DIV4_LAST;
  assign to_restart = rx_stop_mid || rx_fifo_read;
  assign to_set = st.bit_tick && !rx_fifo_empty && rx_below_trigger
                  && st.to_cnt == to_limit - 7'h1;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Pin synchronisers
    next_st.rx_s1 = rx_in;
    next_st.rx_s2 = st.rx_s1;
    next_st.rx_s3 = st.rx_s2;
    next_st.md_s1 = modem_in;
    next_st.md_s2 = st.md_s1;
    next_st.md_s3 = st.md_s2;
    next_st.smp_tick = 1'b0;
    next_st.bit_tick = 1'b0;
    // Register writes and reads
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_IRQ_EN: next_st.irq_enable_ctrl = reg_wdata;
        OFS_LINE_CTRL: next_st.line_control = reg_wdata;
        OFS_MODEM_CTRL: next_st.modem_control = reg_wdata;
        OFS_ENH_FEAT: next_st.enhanced_feature_ctrl = reg_wdata;
        OFS_SMP_ADJ: next_st.sample_count_adjust = reg_wdata[3:0];
        OFS_CLK_NUM: next_st.clock_prescale_numerator = reg_wdata[3:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_DIV_LOW: next_st.rdata = baud_divisor_low;
        OFS_DIV_HIGH: next_st.rdata = baud_divisor_high;
        OFS_IRQ_EN: next_st.rdata = st.irq_enable_ctrl;
        OFS_LINE_CTRL: next_st.rdata = st.line_control;
        OFS_MODEM_CTRL: next_st.rdata = st.modem_control;
        OFS_ENH_FEAT: next_st.rdata = st.enhanced_feature_ctrl;
        OFS_SMP_ADJ: next_st.rdata = {4'h0, st.sample_count_adjust};
        OFS_CLK_NUM: next_st.rdata = {4'h0, st.clock_prescale_numerator};
        OFS_STATUS: next_st.rdata = {4'h0, st.brk_flag, st.to_flag,
                                     !st.clk_on, st.asleep};
        default: next_st.rdata = 8'h00;
      endcase
    end
    if (soft_rst) begin
      next_st.line_control = LINE_CTRL_RST;
      next_st.modem_control = CTRL_RST;
      next_st.irq_enable_ctrl = CTRL_RST;
      next_st.enhanced_feature_ctrl = CTRL_RST;
      next_st.sample_count_adjust = FIELD_RST;
      next_st.clock_prescale_numerator = FIELD_RST;
    end
    if (st.asleep) begin
      if (wake || !sleep_ok) begin
        next_st.asleep = 1'b0;
      end
    end else if (enter && !wake) begin
      next_st.asleep = 1'b1;
    end
    next_st.clk_on = !next_st.asleep;
    if (!st.asleep && divisor != 16'h0) begin
      next_st.pre_cnt = pre_done ? 2'h0 : st.pre_cnt + 2'h1;
      if (pre_done) begin
        if (st.div_cnt >= divisor - 16'h1) begin
          next_st.div_cnt = 16'h0;
          next_st.smp_tick = 1'b1;
          if (st.smp_cnt >= srate_last) begin
            next_st.smp_cnt = 6'h0;
            next_st.bit_tick = 1'b1;
          end else begin
            next_st.smp_cnt = st.smp_cnt + 6'h1;
          end
        end else begin
          next_st.div_cnt = st.div_cnt + 16'h1;
        end
      end
    end
    if (to_restart || rx_fifo_empty || !rx_below_trigger) begin
      next_st.to_cnt = 7'h0;
    end else if (st.bit_tick && st.to_cnt < to_limit) begin
      next_st.to_cnt = st.to_cnt + 7'h1;
    end
    next_st.to_flag = to_set || (st.to_flag && !to_restart);
    if (st.rx_s2) begin
      next_st.brk_cnt = 5'h0;
      next_st.brk_flag = 1'b0;
    end else if (st.bit_tick && st.brk_cnt <= char_bits) begin
      next_st.brk_cnt = st.brk_cnt + 5'h1;
    end
    if (!st.rx_s2 && st.brk_cnt > char_bits) begin
      next_st.brk_flag = 1'b1;
    end
    next_st.tx_line = !st.line_control[SEND_BREAK_BIT] && tx_data_in;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs from flops
  assign reg_rdata = st.rdata;
  assign tx_out = st.tx_line;
  assign asleep = st.asleep;
  assign uart_clk_en = st.clk_on;
  assign sample_tick = st.smp_tick;
  assign bit_tick = st.bit_tick;
  assign rx_timeout = st.to_flag;
  assign break_det = st.brk_flag;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence seq_asleep_held;
    st.asleep ##1 st.asleep;
  endsequence
  sequence seq_zero_div;
    (divisor == 16'h0) [*2];
  endsequence

  AST_SLEEP_PERMIT: assert property (
    !sleep_ok |=> !st.asleep) else $error("asleep without permission");
  AST_SLEEP_ENTRY: assert property (
    $rose(st.asleep) |-> $past(enter)) else $error("bad sleep entry");
  AST_NO_SLEEP_RXDATA: assert property (
    !st.asleep && !rx_fifo_empty |=> !st.asleep)
    else $error("slept with rx data");
  AST_CLK_GATED: assert property (
    seq_asleep_held |-> $stable(st.div_cnt) && !uart_clk_en
    && !st.smp_tick) else $error("clock ran in sleep");
  AST_WAKE: assert property (
    st.asleep && wake |=> !st.asleep && uart_clk_en)
    else $error("missed wake");
  AST_TIMEOUT_SET: assert property (
    $rose(st.to_flag) |-> $past(st.bit_tick)
    && $past(st.to_cnt) == to_limit - 7'h1)
    else $error("time-out at wrong count");
  AST_TIMEOUT_RESTART: assert property (
    to_restart |=> st.to_cnt == 7'h0) else $error("time-out not restarted");
  AST_BREAK_DET: assert property (
    $rose(st.brk_flag) |-> !st.rx_s3 && $past(st.brk_cnt) > char_bits)
    else $error("early break");
  AST_SEND_BREAK: assert property (
    st.line_control[SEND_BREAK_BIT] |=> !tx_out)
    else $error("tx not held low");
  AST_ZERO_DIV: assert property (
    seq_zero_div |-> !st.smp_tick && !st.bit_tick)
    else $error("tick with zero divisor");

endmodule

// ### core/uart_sleep_baud_pkg.sv
// Purpose: Constants for the sleep, time-out, break and baud block
// Assumes: 8-bit register port with a 4-bit register index
// Notes: Divisor bytes have no reset value
package uart_sleep_baud_pkg;
  // ---------------------------------------------------------------
  // Register indexes
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_DIV_LOW = 4'h0;
  localparam logic [3:0] OFS_DIV_HIGH = 4'h1;
  localparam logic [3:0] OFS_IRQ_EN = 4'h2;
  localparam logic [3:0] OFS_LINE_CTRL = 4'h3;
  localparam logic [3:0] OFS_MODEM_CTRL = 4'h4;
  localparam logic [3:0] OFS_ENH_FEAT = 4'h5;
  localparam logic [3:0] OFS_SMP_ADJ = 4'h6;
  localparam logic [3:0] OFS_CLK_NUM = 4'h7;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ENH_FUNC_BIT = 4;
  localparam int SLEEP_EN_BIT = 4;
  localparam int STOP_BITS_BIT = 2;
  localparam int PARITY_EN_BIT = 3;
  localparam int SEND_BREAK_BIT = 6;
  localparam int PRESC_SEL_BIT = 7;
  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] LINE_CTRL_RST = 8'h1d;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] FIELD_RST = 4'h0;
  localparam logic [5:0] SAMPLE_BASE = 6'h10;
  localparam logic [1:0] PRESC_DIV4_LAST = 2'h3;
  localparam logic [4:0] START_BITS = 5'h1;
  localparam logic [4:0] MIN_WORD_BITS = 5'h5;
endpackage

// ### verif/remote_station.sv
// Purpose: Remote serial station driving the receive line
// Assumes: One frame of 8 data bits, no parity, one stop bit
// Notes: Paced by the block's bit tick, idle level is high
`timescale 1ns/100ps
module remote_station (
  input wire logic clk_sys, // Bench clock
  input wire logic bit_tick, // Bit pacing
  input wire logic go, // Start one frame
  input wire logic brk, // Hold line low
  output logic rx_line, // Line to receiver
  output logic stop_mid, // Stop bit marker
  output logic busy // Frame in progress
);
  logic [9:0] sh = 10'h3ff;
  logic [3:0] cnt = 4'h0;
  // Shift one bit out per bit tick
  always @(posedge clk_sys) begin
    stop_mid <= 1'b0;
    if (go && cnt == 4'h0) begin
      sh <= {1'b1, 8'ha5, 1'b0};
      cnt <= 4'ha;
    end else if (bit_tick && cnt != 4'h0) begin
      sh <= {1'b1, sh[9:1]};
      cnt <= cnt - 4'h1;
      stop_mid <= (cnt == 4'h2); // Entering stop bit
    end
  end
  // Idle line rests at mark level
  assign rx_line = brk ? 1'b0 : (cnt != 4'h0 ? sh[0] : 1'b1);
  // Receiver stays busy for the whole frame
  assign busy = cnt != 4'h0;
endmodule

// ### verif/uart_sleep_baud_bench.sv
// Purpose: Self-checking bench for sleep, time-out, break, baud
// Assumes: Inputs driven on the falling edge of clk_sys
// Notes: Tick periods measured between two later ticks
`timescale 1ns/100ps
module uart_sleep_baud_bench;
  import uart_sleep_baud_pkg::*;
  logic clk_sys = 0, rst = 1, soft_rst = 0, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 4'h0, modem_in = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
  logic rx_busy, rx_fifo_empty = 1, rx_below_trigger = 1;
  logic rx_fifo_read = 0, tx_fifo_empty = 1, tx_shift_empty = 1;
  logic tx_fifo_write = 0, irq_other = 0, tx_data_in = 1;
  logic go = 0, brk = 0, rx_in, rx_stop_mid;
  logic tx_out, asleep, uart_clk_en, sample_tick, bit_tick;
  logic rx_timeout, break_det;
  int n_errors = 0, cmp_count = 0, p;
  always #25 clk_sys = ~clk_sys;
  uart_sleep_baud u_dut (.clk_sys, .rst, .soft_rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .rx_in, .modem_in, .rx_busy,
    .rx_fifo_empty, .rx_below_trigger, .rx_fifo_read, .rx_stop_mid,
    .tx_fifo_empty, .tx_shift_empty, .tx_fifo_write, .irq_other,
    .tx_data_in, .tx_out, .asleep, .uart_clk_en, .sample_tick,
    .bit_tick, .rx_timeout, .break_det);
  remote_station u_far (.clk_sys, .bit_tick, .go, .brk,
    .rx_line(rx_in), .stop_mid(rx_stop_mid), .busy(rx_busy));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk_sys);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    reg_rd = 1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 0;
    v = reg_rdata;
  endtask
  task automatic pl(ref logic s);
    @(negedge clk_sys);
    s = 1;
    @(negedge clk_sys);
    s = 0;
  endtask
  function automatic logic tk(input bit b);
    return b ? bit_tick : sample_tick;
  endfunction
  // Cycles between ticks, 400 when none come
  task automatic per(input bit b, output int n);
    int i;
    repeat (2) begin
      i = 0;
      while (tk(b) !== 1'b1 && i < 400) begin
        @(negedge clk_sys);
        i++;
      end
      @(negedge clk_sys);
    end
    n = 1;
    while (tk(b) !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(OFS_LINE_CTRL, d); chk("line_ctrl", d, 16'h1d);
    rd(OFS_MODEM_CTRL, d); chk("modem_ctrl", d, 16'h00);
    rd(4'h9, d); chk("unmapped", d, 16'h00);
    chk("tx_idle", tx_out, 16'h1);
  endtask
  task automatic t_baud;
    wr(OFS_DIV_LOW, 8'h02);
    wr(OFS_DIV_HIGH, 8'h00);
    per(0, p); chk("smp_div2", p, 16'd2);
    per(1, p); chk("bit_16", p, 16'd32);
    wr(OFS_MODEM_CTRL, 8'h80);
    per(0, p); chk("smp_pre4", p, 16'd8);
    wr(OFS_MODEM_CTRL, 8'h00);
    wr(OFS_SMP_ADJ, 8'h0c);
    wr(OFS_CLK_NUM, 8'h03);
    per(1, p); chk("bit_7", p, 16'd14);
    wr(OFS_DIV_LOW, 8'h00);
    per(0, p); chk("smp_zero", p, 16'd400);
    wr(OFS_DIV_HIGH, 8'h01);
    per(0, p); chk("smp_256", p, 16'd256);
    wr(OFS_DIV_HIGH, 8'h00);
    wr(OFS_DIV_LOW, 8'h02);
    wr(OFS_CLK_NUM, 8'h00);
    per(1, p); chk("bit_4", p, 16'd8);
  endtask
  task automatic t_send_break;
    wr(OFS_LINE_CTRL, 8'h40);
    cyc(20); chk("tx_brk", tx_out, 16'h0);
    wr(OFS_LINE_CTRL, 8'h03);
    cyc(2); chk("tx_free", tx_out, 16'h1);
    tx_data_in = 0;
    cyc(2); chk("tx_data", tx_out, 16'h0);
    tx_data_in = 1;
  endtask
  task automatic t_sleep;
    wr(OFS_ENH_FEAT, 8'h10);
    cyc(4); chk("no_perm", asleep, 16'h0);
    wr(OFS_IRQ_EN, 8'h10);
    cyc(4); chk("sleep", asleep, 16'h1);
    chk("gate", uart_clk_en, 16'h0);
    // A transmit write leaves the transmit FIFO non-empty
    tx_fifo_empty = 0;
    pl(tx_fifo_write);
    cyc(2); chk("wake_tx", asleep, 16'h0);
    tx_fifo_empty = 1;
    rx_fifo_empty = 0;
    cyc(6); chk("rx_data", asleep, 16'h0);
    rx_fifo_empty = 1;
    cyc(4); chk("resleep", asleep, 16'h1);
    // Modem change also raises a modem status interrupt
    modem_in = 4'h1;
    irq_other = 1;
    cyc(5); chk("wake_mdm", asleep, 16'h0);
    cyc(6); chk("irq_pend", asleep, 16'h0);
    irq_other = 0;
    cyc(4); chk("resleep2", asleep, 16'h1);
    pl(go);
    cyc(4); chk("wake_rx", asleep, 16'h0);
    cyc(40); chk("rx_frame", asleep, 16'h0);
    cyc(60); chk("resleep3", asleep, 16'h1);
    wr(OFS_IRQ_EN, 8'h00); // Clear sleep enable, which wakes the block
  endtask
  task automatic t_timeout;
    rx_fifo_empty = 0;
    cyc(300); chk("tout_early", rx_timeout, 16'h0);
    cyc(30); chk("tout", rx_timeout, 16'h1);
    pl(rx_fifo_read);
    cyc(2); chk("tout_clr", rx_timeout, 16'h0);
    cyc(200);
    pl(rx_fifo_read);
    cyc(200); chk("tout_rst", rx_timeout, 16'h0);
    cyc(150); chk("tout2", rx_timeout, 16'h1);
    pl(rx_fifo_read);
    rx_fifo_empty = 1;
  endtask
  task automatic t_break;
    brk = 1;
    cyc(60); chk("brk_early", break_det, 16'h0);
    cyc(50); chk("brk", break_det, 16'h1);
    rd(OFS_STATUS, d); chk("status_brk", d, 16'h08);
    brk = 0;
    cyc(6); chk("brk_end", break_det, 16'h0);
  endtask
  task automatic t_resets;
    wr(OFS_DIV_LOW, 8'h07);
    pl(soft_rst);
    rd(OFS_DIV_LOW, d); chk("div_soft", d, 16'h07);
    rd(OFS_LINE_CTRL, d); chk("lc_soft", d, 16'h1d);
    wr(OFS_MODEM_CTRL, 8'h80);
    rst = 1;
    cyc(2);
    rst = 0;
    rd(OFS_DIV_LOW, d); chk("div_hard", d, 16'h07);
    rd(OFS_MODEM_CTRL, d); chk("presc_rst", d, 16'h00);
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #1000000;
    n_errors++;
    end_sim;
  end
  // Main sequence
  initial begin
    cyc(10);
    rst = 0;
    t_reset;
    t_baud;
    t_send_break;
    t_sleep;
    t_timeout;
    t_break;
    t_resets;
    end_sim;
  end
endmodule
